/* hw/gses_pkg.sv */
// Purpose: shared constants and types for the gas sensor error/status block
// Assumes: 20 MHz clock, host reaches the error word through a plain read/write port
// Notes:   bit positions of the error word and baseline-correction timing live here
package gses_pkg;
  // error word layout
  localparam int unsigned ERR_W          = 16;
  localparam int unsigned BIT_FATAL      = 0;
  localparam int unsigned BIT_BUS        = 1;
  localparam int unsigned BIT_ALGO       = 2;
  localparam int unsigned BIT_CAL        = 3;
  localparam int unsigned BIT_DIAG       = 4;
  localparam int unsigned BIT_RANGE      = 5;
  localparam int unsigned BIT_MEM        = 6;
  localparam int unsigned BIT_NOMEAS     = 7;
  localparam int unsigned BIT_LOWV       = 8;
  localparam int unsigned BIT_TIMEOUT    = 9;
  localparam logic [15:0] ERR_RESET      = 16'h0080;
  localparam logic [15:0] ERR_USED_MASK  = 16'h03FF;
  // register map of this port
  localparam logic [7:0]  OFS_ERR        = 8'h00;
  localparam logic [7:0]  OFS_BL_CTRL    = 8'h01;
  localparam logic [7:0]  OFS_BL_PERIOD  = 8'h02;
  localparam logic [7:0]  OFS_BL_REF     = 8'h03;
  // control register fields: enable, and the one-shot force request
  localparam int unsigned CTRL_EN        = 0;
  localparam int unsigned CTRL_FORCE     = 1;
  // baseline-correction reset values; the period counts hours
  localparam logic        BL_EN_RST      = 1'b1;
  localparam logic [15:0] BL_REF_RST     = 16'h0000;
  localparam logic [15:0] BL_PERIOD_HRS  = 16'h00B4;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam longint unsigned HOUR_CYC   = 64'(CLK_HZ) * 64'd3600;

  // error events raised by the sensor core, one-cycle pulses
  typedef struct packed {
    logic fatal;
    logic algo;
    logic cal_fail;
    logic diag;
    logic range;
    logic mem;
    logic lowv;
    logic timeout;
  } gses_evt_s;

  // measurement cycle markers
  typedef struct packed {
    logic start;
    logic done_ok;
  } gses_meas_s;

  typedef enum logic [1:0] {
    BL_IDLE  = 2'b00,
    BL_COUNT = 2'b01,
    BL_APPLY = 2'b11
  } gses_bl_e;
endpackage

/* hw/gses_hour_tick.sv */
// Purpose: divides the clock into one pulse per hour for baseline timing
// Assumes: single clock domain
// Notes:   CYC is a parameter so a simulation can shorten the hour
`timescale 1ns/10ps
`default_nettype none
module gses_hour_tick #(
  parameter longint unsigned CYC = gses_pkg::HOUR_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // output
  output logic      tick_o
);
  import gses_pkg::*;
  logic [37:0] cnt_q;
  wire         wrap = (cnt_q == 38'(CYC - 64'd1));

  // free-running counter; wrap makes the tick
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_q  <= 38'h00_0000_0000;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_q  <= wrap ? 38'h00_0000_0000 : cnt_q + 38'h00_0000_0001;
      tick_o <= wrap;
    end
  end
endmodule // gses_hour_tick
`default_nettype wire

/* hw/gses_top.sv */
// What this block does
// (RULE1) front-end init failure sets bit 0
// (RULE2) access to unmapped address sets bit 1
// (RULE3) any calibration failure sets bit 3
// (RULE4) internal interface failure sets bit 4
// (RULE5) out-of-range sets bit 5, cleared at start
// (RULE6) memory operation error sets bit 6
// (RULE7) bit 7 set at power-up, cleared after measurement
// (RULE8) host polls bit 7 before powering down
// (RULE9) low regulated supply sets bit 8
// (RULE10) timeout sets bit 9, cleared on success
// (RULE11) forced correction only while auto correction enabled
// (RULE12) forced correction uses the stored reference
// (RULE13) forced correction applies at once
// (RULE14) correction period defaults 180 hours, host-writable
// (RULE15) corrupt algorithm parameters set bit 2
// (RULE16) bits 10 to 15 read zero, ignore writes
//
// Purpose: error word and baseline-correction gating of a gas sensor
// Assumes: core events are one-cycle pulses on clk_i; host port is synchronous
// Notes:   error flags other than 5, 7, 9 are sticky until reset or a host
//          write of one to the bit; a new event in the clear cycle wins
`timescale 1ns/10ps
`default_nettype none
module gses_top #(
  parameter longint unsigned HOUR_CYCLES = gses_pkg::HOUR_CYC
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // events from the sensor core
  input  wire gses_pkg::gses_evt_s  evt_i,
  input  wire gses_pkg::gses_meas_s meas_i,
  // host register port
  input  wire logic                 req_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [15:0]          wdata_i,
  output logic                      ack_o,
  output logic [15:0]               rdata_o,
  // error word and baseline correction toward the core
  output logic [15:0]               err_o,
  output logic                      auto_baseline_correction_o,
  output logic                      bl_apply_o,
  output logic [15:0]               bl_ref_o
);
  import gses_pkg::*;

  logic [15:0] err_q, err_d;
  logic        bl_en_q;
  logic [15:0] period_q;
  logic [15:0] hours_q;
  logic [15:0] ref_q;
  logic        force_q;
  gses_bl_e    st_q, st_d;
  logic        hour_tick;

  gses_hour_tick #(
    .CYC      (HOUR_CYCLES)
  ) u_tick (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tick_o   (hour_tick)
  );

  // address decode
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_ERR) || (a == OFS_BL_CTRL) ||
                (a == OFS_BL_PERIOD) || (a == OFS_BL_REF);
  endfunction

  wire acc     = req_i;
  wire wr      = req_i & we_i;
  wire bad_acc = acc & ~is_mapped(addr_i); // RULE2
  wire wr_err  = wr & (addr_i == OFS_ERR);
  wire wr_ctrl = wr & (addr_i == OFS_BL_CTRL);
  wire wr_per  = wr & (addr_i == OFS_BL_PERIOD);
  wire wr_ref  = wr & (addr_i == OFS_BL_REF);
  // a forced request is simply dropped while auto correction is off
  wire force_req = wr_ctrl & wdata_i[CTRL_FORCE] & bl_en_q & wdata_i[CTRL_EN]; // RULE11
  wire [15:0] clr = wr_err ? wdata_i : 16'h0000;

  // event vector in error-word order
  logic [15:0] set_v;
  always_comb
  begin
    set_v              = 16'h0000;
    set_v[BIT_FATAL]   = evt_i.fatal;    // RULE1
    set_v[BIT_BUS]     = bad_acc;        // RULE2
    set_v[BIT_ALGO]    = evt_i.algo;     // RULE15
    set_v[BIT_CAL]     = evt_i.cal_fail; // RULE3
    set_v[BIT_DIAG]    = evt_i.diag;     // RULE4
    set_v[BIT_RANGE]   = evt_i.range;    // RULE5
    set_v[BIT_MEM]     = evt_i.mem;      // RULE6
    set_v[BIT_LOWV]    = evt_i.lowv;     // RULE9
    set_v[BIT_TIMEOUT] = evt_i.timeout;  // RULE10
  end

  // next error word: set beats clear; hardware-cleared bits follow measurement
  always_comb
  begin
    err_d = (err_q & ~clr) | set_v;
    if (meas_i.start && !evt_i.range)
    begin
      err_d[BIT_RANGE] = 1'b0; // RULE5
    end
    if (meas_i.done_ok && !evt_i.timeout)
    begin
      err_d[BIT_TIMEOUT] = 1'b0; // RULE10
    end
    // bit 7 is not host-clearable; only a finished cycle drops it
    err_d[BIT_NOMEAS] = err_q[BIT_NOMEAS] & ~meas_i.done_ok; // RULE7
    err_d = err_d & ERR_USED_MASK; // RULE16
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      err_q <= ERR_RESET; // RULE7
    end
    else
    begin
      err_q <= err_d;
    end
  end

  // baseline-correction control registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bl_en_q  <= BL_EN_RST;
      period_q <= BL_PERIOD_HRS; // RULE14
      ref_q    <= BL_REF_RST;
      force_q  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        bl_en_q <= wdata_i[CTRL_EN];
      end
      if (wr_per)
      begin
        period_q <= wdata_i; // RULE14
      end
      if (wr_ref)
      begin
        ref_q <= wdata_i; // RULE12
      end
      force_q <= force_req;
    end
  end

  // period state machine; forcing skips the rest of the wait
  wire period_up = hour_tick && (hours_q + 16'h0001 >= period_q);
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      BL_IDLE:  st_d = bl_en_q ? BL_COUNT : BL_IDLE;
      BL_COUNT:
      begin
        if (!bl_en_q)
          st_d = BL_IDLE;
        else if (force_q || period_up)
          st_d = BL_APPLY; // RULE13
      end
      BL_APPLY: st_d = bl_en_q ? BL_COUNT : BL_IDLE;
      default:  st_d = BL_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q    <= BL_IDLE;
      hours_q <= 16'h0000;
    end
    else
    begin
      st_q <= st_d;
      if (st_q != BL_COUNT || st_d == BL_APPLY)
        hours_q <= 16'h0000;
      else if (hour_tick)
        hours_q <= hours_q + 16'h0001;
    end
  end

  // read mux
  logic [15:0] rd_mux;
  always_comb
  begin
    case (addr_i)
      OFS_ERR:        rd_mux = err_q;
      OFS_BL_CTRL:    rd_mux = {15'h0000, bl_en_q};
      OFS_BL_PERIOD:  rd_mux = period_q;
      OFS_BL_REF:     rd_mux = ref_q;
      default:        rd_mux = 16'h0000;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ack_o                      <= 1'b0;
      rdata_o                    <= 16'h0000;
      err_o                      <= ERR_RESET;
      auto_baseline_correction_o <= BL_EN_RST;
      bl_apply_o                 <= 1'b0;
      bl_ref_o                   <= BL_REF_RST;
    end
    else
    begin
      ack_o                      <= acc;
      rdata_o                    <= (acc && !we_i) ? rd_mux : 16'h0000;
      err_o                      <= err_d;
      auto_baseline_correction_o <= bl_en_q;
      bl_apply_o                 <= (st_d == BL_APPLY); // RULE13
      bl_ref_o                   <= ref_q;              // RULE12
    end
  end
endmodule // gses_top
`default_nettype wire

/* testbench/gses_top_sva.sv */
// Purpose: concurrent checks on the error word and correction pulse
// Assumes: sees only the ports of gses_top
// Notes:   sticky flags are checked one edge after their event, bit 1 within one to two edges
`timescale 1ns/10ps
`default_nettype none
module gses_chk #(
  parameter longint unsigned HOUR_CYCLES = 64'd10
) (
  // clock and reset
  input wire logic                 clk_i,
  input wire logic                 resetn_i,
  // core events and host port
  input wire gses_pkg::gses_evt_s  evt_i,
  input wire gses_pkg::gses_meas_s meas_i,
  input wire logic                 req_i,
  input wire logic                 we_i,
  input wire logic [7:0]           addr_i,
  input wire logic [15:0]          wdata_i,
  // design outputs
  input wire logic                 ack_o,
  input wire logic [15:0]          rdata_o,
  input wire logic [15:0]          err_o,
  input wire logic                 auto_baseline_correction_o,
  input wire logic                 bl_apply_o,
  input wire logic [15:0]          bl_ref_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // event flags land one edge after the pulse
  property p_fatal; evt_i.fatal |=> err_o[0]; endproperty
  a_fatal: assert property (p_fatal) else $error("fatal flag missing");
  property p_bus; req_i && addr_i > 8'h03 |-> ##[1:2] err_o[1]; endproperty
  a_bus: assert property (p_bus) else $error("bus flag missing");
  property p_cal; evt_i.cal_fail |=> err_o[3]; endproperty
  a_cal: assert property (p_cal) else $error("cal flag missing");
  property p_sticky; (evt_i.diag |=> err_o[4]) and (evt_i.mem |=> err_o[6])
    and (evt_i.lowv |=> err_o[8]) and (evt_i.algo |=> err_o[2]); endproperty
  a_sticky: assert property (p_sticky) else $error("flag missing");
  property p_range; meas_i.start && !evt_i.range |=> !err_o[5]; endproperty
  a_range: assert property (p_range) else $error("range not cleared");
  property p_nomeas; meas_i.done_ok |=> !err_o[7]; endproperty
  a_nomeas: assert property (p_nomeas) else $error("bit 7 not cleared");
  property p_tmo; (meas_i.done_ok && !evt_i.timeout |=> !err_o[9])
    and (evt_i.timeout |=> err_o[9]); endproperty
  a_tmo: assert property (p_tmo) else $error("timeout flag wrong");
  property p_rsv; err_o[15:10] == 6'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  // the enable output one edge on shows what the force met; apply follows, or
  // was already pulsing when a period expiry landed in the same cycle
  property p_force; req_i && we_i && addr_i == 8'h01 && wdata_i[1:0] == 2'b11
    ##1 auto_baseline_correction_o |=> bl_apply_o || $past(bl_apply_o); endproperty
  a_force: assert property (p_force) else $error("force not applied");
endmodule // gses_chk
bind gses_top gses_chk #(.HOUR_CYCLES(HOUR_CYCLES)) u_chk (.clk_i(clk_i),
  .resetn_i(resetn_i), .evt_i(evt_i), .meas_i(meas_i), .req_i(req_i), .we_i(we_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .ack_o(ack_o), .rdata_o(rdata_o), .err_o(err_o),
  .auto_baseline_correction_o(auto_baseline_correction_o), .bl_apply_o(bl_apply_o),
  .bl_ref_o(bl_ref_o));
`default_nettype wire

/* testbench/gses_host_model.sv */
// Purpose: host model driving the register port
// Assumes: one access at a time, changed at the falling edge
// Notes:   a missing ack returns a marker value so it cannot pass
`timescale 1ns/10ps
`default_nettype none
module gses_host_model (
  // clock
  input  wire logic        clk_i,
  // register port
  output logic             req_o,
  output logic             we_o,
  output logic [7:0]       addr_o,
  output logic [15:0]      wdata_o,
  input  wire logic        ack_i,
  input  wire logic [15:0] rdata_i
);
  initial {req_o, we_o, addr_o, wdata_o} = '0;
  // request stands one cycle; ack stands only the cycle after, so take it then
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge clk_i);
    {req_o, we_o, addr_o, wdata_o} = {1'b1, w, a, d};
    @(negedge clk_i);
    q = ack_i ? rdata_i : 16'hDEAD;
    req_o = 1'b0;
  endtask
endmodule // gses_host_model
`default_nettype wire

/* testbench/tb_gas_sensor_error_status.sv */
// Purpose: self-checking bench for the error word and correction gating
// Assumes: hour shortened to 10 cycles
// Notes:   bit 7 is cleared last since only reset brings it back
`timescale 1ns/10ps
`default_nettype none
module tb_gas_sensor_error_status;
  import gses_pkg::*;
  logic clk_i, resetn_i, req, we, ack, apply, en;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, err, ref_w, q;
  gses_evt_s evt;
  gses_meas_s meas;
  int miscompares = 0, num_checks = 0, cyc = 0;
  gses_top #(.HOUR_CYCLES(64'd10)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .evt_i(evt),
    .meas_i(meas), .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata), .ack_o(ack),
    .rdata_o(rdata), .err_o(err), .auto_baseline_correction_o(en), .bl_apply_o(apply),
    .bl_ref_o(ref_w));
  gses_host_model host (.clk_i(clk_i), .req_o(req), .we_o(we), .addr_o(addr),
    .wdata_o(wdata), .ack_i(ack), .rdata_i(rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    host.acc(1'b0, a, 16'h0000, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.acc(1'b1, a, d, q);
  endtask
  // one-cycle pulse on the core event and measurement lines
  task automatic pulse(input logic [7:0] e, input logic [1:0] m);
    @(negedge clk_i);
    evt = gses_evt_s'(e);
    meas = gses_meas_s'(m);
    @(negedge clk_i);
    evt = '0;
    meas = '0;
  endtask
  // every event sets its own bit and a write of one clears it
  task automatic t_events;
    int eb[8] = '{0, 2, 3, 4, 5, 6, 8, 9};
    for (int k = 0; k < 8; k++)
    begin
      pulse(8'h80 >> k, 2'b00);
      rd(OFS_ERR);
      check(q, ERR_RESET | (16'h0001 << eb[k]));
      wr(OFS_ERR, 16'h0001 << eb[k]);
    end
  endtask
  // unmapped read answers zero and flags; reserved bits ignore writes
  task automatic t_bus;
    rd(8'h10);
    check(q, 16'h0000);
    rd(OFS_ERR);
    check(q, ERR_RESET | 16'h0002);
    wr(OFS_ERR, 16'hFC82);
    rd(OFS_ERR);
    check(q, ERR_RESET);
  endtask
  // gating first while disabled, so no period expiry can meet the force;
  // then shared reference, forced apply and a short period running out
  task automatic t_abc;
    int idle_hits = 0;
    int hits = 0;
    rd(OFS_BL_PERIOD);
    check(q, BL_PERIOD_HRS);
    wr(OFS_BL_CTRL, 16'h0000);
    wr(OFS_BL_CTRL, 16'h0002);
    repeat (3)
    begin
      @(negedge clk_i);
      idle_hits += apply;
    end
    check({15'h0000, en}, 16'h0000);
    check(16'(idle_hits), 16'h0000);
    wr(OFS_BL_PERIOD, 16'h0007);
    rd(OFS_BL_PERIOD);
    check(q, 16'h0007);
    wr(OFS_BL_REF, 16'h1234);
    @(negedge clk_i);
    check(ref_w, 16'h1234);
    wr(OFS_BL_CTRL, 16'h0001);
    wr(OFS_BL_CTRL, 16'h0003);
    @(negedge clk_i);
    check({15'h0000, apply}, 16'h0001);
    @(negedge clk_i);
    check({15'h0000, apply}, 16'h0000);
    wr(OFS_BL_PERIOD, 16'h0002);
    repeat (30)
    begin
      @(negedge clk_i);
      hits += apply;
    end
    check({15'h0000, hits != 0}, 16'h0001);
  endtask
  // start clears range, success clears timeout and the no-measurement bit
  task automatic t_meas;
    pulse(8'h08, 2'b00);
    pulse(8'h00, 2'b10);
    rd(OFS_ERR);
    check(q, ERR_RESET);
    pulse(8'h01, 2'b00);
    rd(OFS_ERR);
    check(q, ERR_RESET | 16'h0200);
    pulse(8'h00, 2'b01);
    rd(OFS_ERR);
    check(q, 16'h0000);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // cut a hang short
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      final_report;
    end
  end
  initial
  begin
    resetn_i = 1'b0;
    evt = '0;
    meas = '0;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    check(err, ERR_RESET);
    t_events;
    t_bus;
    t_abc;
    t_meas;
    final_report;
  end
endmodule // tb_gas_sensor_error_status
`default_nettype wire
